// ===== qpd_map.svh
`ifndef QPD_MAP_SVH
`define QPD_MAP_SVH
// register byte addresses
`define CTRL_ADDR      12'h000
`define MAXPOS_ADDR    12'h004
`define POS_ADDR       12'h008
`define STAT_ADDR      12'h00c
`define VELCFG_ADDR    12'h010
`define VEL_ADDR       12'h014
`define RIS_ADDR       12'h018
`define MASK_ADDR      12'h01c
`define MIS_ADDR       12'h020
// control fields
`define CTRL_ENABLE    0
`define CTRL_BOTH      1
`define CTRL_RESET_IDX 2
`define CTRL_CLKDIR    3
`define CTRL_SWAP      4
`define CTRL_VEL_EN    5
`define CTRL_FILT_EN   6
`define CTRL_FILT_LSB  8
`define CTRL_FILT_W    4
// event bit positions
`define EV_ERROR       0
`define EV_DIR         1
`define EV_TIMER       2
`define EV_INDEX       3
`define FILT_BASE      5'd2
`define VEL_PERIOD_RST 32'h0000_0001
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10
`endif

// ===== qpd_pkg.sv
`default_nettype none
package qpd_pkg;
   typedef struct packed {
      logic a;
      logic b;
      logic idx;
   } enc_s;
   typedef struct packed {
      logic index;
      logic timer;
      logic dir;
      logic error;
   } events_s;
endpackage : qpd_pkg
`default_nettype wire

// ===== quad_encoder_model.sv
`timescale 1ns/10ps
`default_nettype none
module quad_encoder_model (
   input  wire logic step_in,
   input  wire logic clock_in,
   input  wire logic fwd_in,
   input  wire logic step_mode_in,
   input  wire logic glitch_in,
   output logic      first_out,
   output logic      second_out
);
   logic [1:0] phase_reg = 2'h0;
   // glitch moves both lines at once in quadrature mode (neither in step mode), used only when a scenario asks for a fault
   always @(posedge clock_in) begin
      if (glitch_in)
         phase_reg <= phase_reg + 2'h2;
      else if (step_in)
         phase_reg <= fwd_in ? phase_reg + 2'h1 : phase_reg - 2'h1;
   end
   // first line leads when moving forward; step mode gives a clock plus a level
   assign first_out  = step_mode_in ? phase_reg[0] : phase_reg[1] ^ phase_reg[0];
   assign second_out = step_mode_in ? ~fwd_in : phase_reg[1];
endmodule : quad_encoder_model
`default_nettype wire

// ===== quadrature_position_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "qpd_map.svh"
module quadrature_position_decoder
   import qpd_pkg::*;
#(
   parameter int POS_W = 32
) (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        encoder_input_first_in,
   input  wire logic        encoder_input_second_in,
   input  wire logic        index_in,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_out,
   output logic             direction_out,
   output logic             error_out
);
   // byte-enable merge, used by the ctrl, maxpos, position and velcfg registers; mask and interrupt status take byte 0 only
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // ---------------- register and pipeline state
   logic [31:0]      ctrl_reg, ctrl_next;
   logic [POS_W-1:0] maxpos_reg, maxpos_next;
   logic [POS_W-1:0] pos_reg, pos_next;
   logic [31:0]      velcfg_reg, velcfg_next;
   logic [31:0]      vel_reg, vel_next;
   logic [31:0]      velacc_reg, velacc_next;
   logic [31:0]      veltmr_reg, veltmr_next;
   logic [3:0]       ris_reg, ris_next;
   logic [3:0]       mask_reg, mask_next;
   logic             dir_reg, dir_next;
   logic             err_reg, err_next;
   enc_s             raw_reg, filt_reg, filt_next, prev_reg, prev_next;
   logic [4:0]       fcnt_reg, fcnt_next;
   logic             aw_reg, aw_next, w_reg, w_next;
   logic [11:0]      awaddr_reg, awaddr_next, araddr_reg, araddr_next;
   logic [31:0]      wdata_reg, wdata_next;
   logic [3:0]       wstrb_reg, wstrb_next;
   logic             bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic             ar_reg, ar_next;
   logic [1:0]       bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0]      rdata_reg, rdata_next;
   logic             irq_reg, irq_next;

   // ---------------- encoder datapath
   enc_s             in_sw, dec;
   logic             edge_a, edge_b, count_pulse, move_fwd, idx_rise;
   logic [4:0]       filt_len;
   events_s          ev;
   logic             do_write;
   logic [31:0]      wval;

   // swap before anything else touches the channels
   always_comb begin
      in_sw.a   = ctrl_reg[`CTRL_SWAP] ? raw_reg.b : raw_reg.a;
      in_sw.b   = ctrl_reg[`CTRL_SWAP] ? raw_reg.a : raw_reg.b;
      in_sw.idx = raw_reg.idx;
   end

   // glitch filter: a new level must hold for filt_len samples before it is taken
   always_comb begin
      filt_len  = `FILT_BASE + {1'b0, ctrl_reg[`CTRL_FILT_LSB +: `CTRL_FILT_W]};
      filt_next = filt_reg;
      fcnt_next = 5'd0;
      if (!ctrl_reg[`CTRL_FILT_EN]) begin
         filt_next = in_sw;
      end else if (in_sw != filt_reg) begin
         fcnt_next = fcnt_reg + 5'd1;
         if (fcnt_reg + 5'd1 >= filt_len) begin
            filt_next = in_sw;
            fcnt_next = 5'd0;
         end
      end
      dec       = filt_reg;
      prev_next = dec;
   end

   // edge detection and direction decode
   always_comb begin
      edge_a   = dec.a != prev_reg.a;
      edge_b   = dec.b != prev_reg.b;
      idx_rise = dec.idx & ~prev_reg.idx;
      if (ctrl_reg[`CTRL_CLKDIR]) begin
         count_pulse = edge_a & dec.a;
         move_fwd    = ~dec.b;
      end else begin
         count_pulse = ((edge_a ^ edge_b) & (ctrl_reg[`CTRL_BOTH] | edge_a));
         move_fwd    = edge_a ? (dec.a ^ dec.b) : ~(dec.a ^ dec.b);
      end
   end

   // position, direction, error, velocity
   always_comb begin
      pos_next    = pos_reg;
      dir_next    = dir_reg;
      err_next    = err_reg;
      vel_next    = vel_reg;
      velacc_next = velacc_reg;
      veltmr_next = veltmr_reg;
      ev          = '0;
      if (ctrl_reg[`CTRL_ENABLE]) begin
         if (!ctrl_reg[`CTRL_CLKDIR] && edge_a && edge_b) begin
            err_next = 1'b1;
            ev.error = 1'b1;
         end
         if (count_pulse) begin
            dir_next = move_fwd;
            ev.dir   = move_fwd != dir_reg;
            if (move_fwd) begin
               pos_next = (pos_reg >= maxpos_reg) ? '0 : pos_reg + POS_W'(1);
            end else begin
               pos_next = (pos_reg == '0) ? maxpos_reg : pos_reg - POS_W'(1);
            end
         end
         if (idx_rise) begin
            ev.index = 1'b1;
            if (ctrl_reg[`CTRL_RESET_IDX]) begin
               pos_next = (count_pulse ? move_fwd : dir_reg) ? '0 : maxpos_reg;
            end
         end
         if (ctrl_reg[`CTRL_VEL_EN]) begin
            velacc_next = velacc_reg + {31'd0, count_pulse};
            veltmr_next = veltmr_reg + 32'd1;
            if (veltmr_reg + 32'd1 >= velcfg_reg) begin
               vel_next    = velacc_next;
               velacc_next = '0;
               veltmr_next = '0;
               ev.timer    = 1'b1;
            end
         end
      end
      if (do_write && awaddr_reg == `POS_ADDR) begin
         pos_next = merge(pos_reg, wval, wstrb_reg);
      end
   end

   // ---------------- axi4-lite slave: address and data may arrive in either order
   always_comb begin
      aw_next     = aw_reg;
      w_next      = w_reg;
      awaddr_next = awaddr_reg;
      wdata_next  = wdata_reg;
      wstrb_next  = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next  = bresp_reg;
      if (s_axi_awvalid && !aw_reg) begin
         aw_next     = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_reg) begin
         w_next     = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      do_write = aw_reg && w_reg && !bvalid_reg;
      wval     = wdata_reg;
      if (do_write) begin
         aw_next     = 1'b0;
         w_next      = 1'b0;
         bvalid_next = 1'b1;
         unique case (awaddr_reg)
            `CTRL_ADDR, `MAXPOS_ADDR, `POS_ADDR, `VELCFG_ADDR, `RIS_ADDR,
            `MASK_ADDR: bresp_next = `AXI_OKAY;
            default:    bresp_next = `AXI_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   // writable configuration; interrupt status is write-one-to-clear, set wins
   always_comb begin
      ctrl_next   = ctrl_reg;
      maxpos_next = maxpos_reg;
      velcfg_next = velcfg_reg;
      mask_next   = mask_reg;
      ris_next    = ris_reg;
      if (do_write) begin
         unique case (awaddr_reg)
            `CTRL_ADDR:   ctrl_next   = merge(ctrl_reg, wval, wstrb_reg);
            `MAXPOS_ADDR: maxpos_next = merge(maxpos_reg, wval, wstrb_reg);
            `VELCFG_ADDR: velcfg_next = merge(velcfg_reg, wval, wstrb_reg);
            `MASK_ADDR:   mask_next   = wstrb_reg[0] ? wval[3:0] : mask_reg;
            `RIS_ADDR:    ris_next    = wstrb_reg[0] ? ris_reg & ~wval[3:0] : ris_reg;
            default:      ;
         endcase
      end
      ris_next = ris_next | ev;
      irq_next = |(ris_next & mask_next);
   end

   // read channel, answers one cycle after the address is taken
   always_comb begin
      ar_next     = 1'b0;
      araddr_next = araddr_reg;
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_arvalid && !ar_reg && !rvalid_reg) begin
         ar_next     = 1'b1;
         araddr_next = s_axi_araddr;
      end
      if (ar_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = `AXI_OKAY;
         unique case (araddr_reg)
            `CTRL_ADDR:   rdata_next = ctrl_reg;
            `MAXPOS_ADDR: rdata_next = maxpos_reg;
            `POS_ADDR:    rdata_next = pos_reg;
            `STAT_ADDR:   rdata_next = {30'd0, err_reg, dir_reg};
            `VELCFG_ADDR: rdata_next = velcfg_reg;
            `VEL_ADDR:    rdata_next = vel_reg;
            `RIS_ADDR:    rdata_next = {28'd0, ris_reg};
            `MASK_ADDR:   rdata_next = {28'd0, mask_reg};
            `MIS_ADDR:    rdata_next = {28'd0, ris_reg & mask_reg};
            default: begin
               rdata_next = '0;
               rresp_next = `AXI_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // all state registers; inputs sampled once before swap/filter
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         raw_reg <= '0; filt_reg <= '0; prev_reg <= '0; fcnt_reg <= '0;
         ctrl_reg <= '0; maxpos_reg <= '0; pos_reg <= '0;
         velcfg_reg <= `VEL_PERIOD_RST; vel_reg <= '0; velacc_reg <= '0; veltmr_reg <= '0;
         ris_reg <= '0; mask_reg <= '0; dir_reg <= 1'b1; err_reg <= 1'b0;
         aw_reg <= 1'b0; w_reg <= 1'b0; awaddr_reg <= '0; wdata_reg <= '0; wstrb_reg <= '0;
         bvalid_reg <= 1'b0; bresp_reg <= '0; ar_reg <= 1'b0; araddr_reg <= '0;
         rvalid_reg <= 1'b0; rdata_reg <= '0; rresp_reg <= '0; irq_reg <= 1'b0;
      end else begin
         raw_reg <= '{a: encoder_input_first_in, b: encoder_input_second_in, idx: index_in};
         filt_reg <= filt_next; prev_reg <= prev_next; fcnt_reg <= fcnt_next;
         ctrl_reg <= ctrl_next; maxpos_reg <= maxpos_next; pos_reg <= pos_next;
         velcfg_reg <= velcfg_next; vel_reg <= vel_next;
         velacc_reg <= velacc_next; veltmr_reg <= veltmr_next;
         ris_reg <= ris_next; mask_reg <= mask_next; dir_reg <= dir_next; err_reg <= err_next;
         aw_reg <= aw_next; w_reg <= w_next; awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next; wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next; bresp_reg <= bresp_next; ar_reg <= ar_next;
         araddr_reg <= araddr_next; rvalid_reg <= rvalid_next; rdata_reg <= rdata_next;
         rresp_reg <= rresp_next; irq_reg <= irq_next;
      end
   end

   // outputs straight from flops; ready held low while a slot is occupied
   assign s_axi_awready = ~aw_reg;
   assign s_axi_wready  = ~w_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ~ar_reg & ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign irq_out       = irq_reg;
   assign direction_out = dir_reg;
   assign error_out     = err_reg;

   // ---------------- checks
   property p_irq_masked;
      @(posedge clock_in) disable iff (rst_in) irq_out |-> |($past(ris_next & mask_next));
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq without unmasked event");
   property p_err_sticky;
      @(posedge clock_in) disable iff (rst_in) $rose(error_out) |=> error_out [*4];
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");
   property p_dir_hold;
      @(posedge clock_in) disable iff (rst_in) !count_pulse |=> $stable(direction_out);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed at rest");
   property p_pos_bound;
      @(posedge clock_in) disable iff (rst_in)
         ctrl_reg[`CTRL_RESET_IDX] && $past(pos_reg <= maxpos_reg) && $stable(maxpos_reg)
         && !$past(do_write) |-> pos_reg <= maxpos_reg;
   endproperty
   a_pos_bound: assert property (p_pos_bound) else $error("position above maximum");
   property p_idx_rev;
      @(posedge clock_in) disable iff (rst_in)
         ctrl_reg[`CTRL_ENABLE] && ctrl_reg[`CTRL_RESET_IDX] && idx_rise && !count_pulse
         && !dir_reg && !do_write |=> pos_reg == $past(maxpos_reg);
   endproperty
   a_idx_rev: assert property (p_idx_rev) else $error("reverse index did not load maximum");
   property p_no_idx_reset;
      @(posedge clock_in) disable iff (rst_in)
         !ctrl_reg[`CTRL_RESET_IDX] && !count_pulse && !do_write |=> $stable(pos_reg);
   endproperty
   a_no_idx_reset: assert property (p_no_idx_reset) else $error("position moved with no edge");
   property p_mis;
      @(posedge clock_in) disable iff (rst_in) ##1 irq_out == |(ris_reg & mask_reg);
   endproperty
   a_mis: assert property (p_mis) else $error("interrupt differs from masked status");
   property p_clear_keep;
      @(posedge clock_in) disable iff (rst_in)
         do_write && awaddr_reg == `RIS_ADDR && wstrb_reg[0]
         |=> (($past(ris_reg & ~wval[3:0]) & ~ris_reg) == 4'h0)
             && ((ris_reg & $past(wval[3:0] & ~4'(ev))) == 4'h0);
   endproperty
   a_clear_keep: assert property (p_clear_keep) else $error("unselected event altered");
endmodule : quadrature_position_decoder
`default_nettype wire

// ===== quadrature_position_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "qpd_map.svh"
module quadrature_position_decoder_test;
   logic        clock = 1'b0, rst = 1'b1, step = 1'b0, fwd = 1'b1, smode = 1'b0;
   logic        glitch = 1'b0, idx = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic        awready, wready, bvalid, arready, rvalid, irq, dir, err;
   logic [1:0]  bresp, rresp, resp;
   wire logic   enc_a, enc_b;
   int          n_fail = 0, num_checks = 0;
   // rows: address, expected data, expected response right after reset
   localparam logic [45:0] ROWS [0:9] = '{{`CTRL_ADDR, 32'h0, `AXI_OKAY},
      {`MAXPOS_ADDR, 32'h0, `AXI_OKAY}, {`POS_ADDR, 32'h0, `AXI_OKAY},
      {`STAT_ADDR, 32'h1, `AXI_OKAY}, {`VELCFG_ADDR, `VEL_PERIOD_RST, `AXI_OKAY},
      {`VEL_ADDR, 32'h0, `AXI_OKAY}, {`RIS_ADDR, 32'h0, `AXI_OKAY},
      {`MASK_ADDR, 32'h0, `AXI_OKAY}, {`MIS_ADDR, 32'h0, `AXI_OKAY},
      {12'h024, 32'h0, `AXI_SLVERR}};
   always #25 clock = ~clock;
   quad_encoder_model u_enc (.clock_in(clock), .step_in(step), .fwd_in(fwd),
      .step_mode_in(smode), .glitch_in(glitch), .first_out(enc_a), .second_out(enc_b));
   // responses are always accepted, so bready and rready stay high
   quadrature_position_decoder u_dut (.clock_in(clock), .rst_in(rst),
      .encoder_input_first_in(enc_a), .encoder_input_second_in(enc_b), .index_in(idx),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .irq_out(irq),
      .direction_out(dir), .error_out(err));
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_pin(input logic g, input logic e);
      chk_word({31'h0, g}, {31'h0, e});
   endtask : chk_pin
   // each channel is released at the edge where its own ready is seen
   // only the watchdog ends a wait, so a silent slave cannot pass
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      got = rdata;
      resp = rresp;
   endtask : rd
   // one encoder advance per request, then let the decoder settle
   task automatic mv(input int n, input logic f, input int settle);
      repeat (n) begin
         step <= 1'b1;
         fwd <= f;
         @(posedge clock);
         step <= 1'b0;
         repeat (settle) @(posedge clock);
      end
   endtask : mv
   task automatic pulse_idx;
      idx <= 1'b1;
      @(posedge clock);
      idx <= 1'b0;
      repeat (6) @(posedge clock);
   endtask : pulse_idx
   task automatic pos_is(input logic [31:0] e);
      rd(`POS_ADDR);
      chk_word(got, e);
   endtask : pos_is
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         rd(ROWS[i][45:34]);
         chk_word(got, ROWS[i][33:2]);
         chk_word({30'h0, resp}, {30'h0, ROWS[i][1:0]});
      end
      wr(12'h030, 32'h0);
      chk_word({30'h0, resp}, {30'h0, `AXI_SLVERR});
      // maximum position goes in before the enable
      wr(`MAXPOS_ADDR, 32'h9);
      wr(`CTRL_ADDR, 32'h3);
      mv(3, 1'b1, 6);
      pos_is(32'h3);
      pulse_idx();
      pos_is(32'h3);
      mv(4, 1'b0, 6);
      pos_is(32'h9);
      repeat (20) @(posedge clock);
      chk_pin(dir, 1'b0);
      rd(`RIS_ADDR);
      chk_word(got & 32'h2, 32'h2);
      // first channel only: five steps cross two edges of that channel
      wr(`CTRL_ADDR, 32'h1);
      wr(`POS_ADDR, 32'h0);
      mv(5, 1'b1, 6);
      pos_is(32'h2);
      chk_pin(dir, 1'b1);
      wr(`CTRL_ADDR, 32'h13);
      wr(`POS_ADDR, 32'h0);
      mv(2, 1'b1, 6);
      pos_is(32'h8);
      // step and direction: two toggles of the clock line make one step
      wr(`CTRL_ADDR, 32'h9);
      smode <= 1'b1;
      wr(`POS_ADDR, 32'h0);
      mv(6, 1'b1, 6);
      pos_is(32'h3);
      mv(4, 1'b0, 6);
      pos_is(32'h1);
      smode <= 1'b0;
      wr(`CTRL_ADDR, 32'h7);
      wr(`POS_ADDR, 32'h5);
      mv(1, 1'b1, 6);
      pulse_idx();
      pos_is(32'h0);
      rd(`RIS_ADDR);
      chk_word(got & 32'h8, 32'h8);
      mv(2, 1'b0, 6);
      pos_is(32'h8);
      pulse_idx();
      pos_is(32'h9);
      mv(1, 1'b1, 6);
      pos_is(32'h0);
      // longest filter: the step must not show before seventeen samples
      wr(`CTRL_ADDR, 32'h0f03);
      wr(`CTRL_ADDR, 32'h0f43);
      mv(1, 1'b1, 6);
      pos_is(32'h0);
      repeat (30) @(posedge clock);
      pos_is(32'h1);
      wr(`CTRL_ADDR, 32'h0f03);
      mv(1, 1'b1, 5);
      pos_is(32'h2);
      glitch <= 1'b1;
      @(posedge clock);
      glitch <= 1'b0;
      repeat (6) @(posedge clock);
      chk_pin(err, 1'b1);
      wr(`VELCFG_ADDR, 32'd20);
      wr(`CTRL_ADDR, 32'h23);
      repeat (30) @(posedge clock);
      rd(`RIS_ADDR);
      chk_word(got & 32'hf, 32'hf);
      // a long window holds all four steps; read once that window has closed
      wr(`VELCFG_ADDR, 32'd400);
      mv(4, 1'b1, 6);
      repeat (400) @(posedge clock);
      rd(`VEL_ADDR);
      chk_word(got, 32'd4);
      wr(`MASK_ADDR, 32'h0);
      repeat (2) @(posedge clock);
      chk_pin(irq, 1'b0);
      wr(`MASK_ADDR, 32'h1);
      repeat (2) @(posedge clock);
      chk_pin(irq, 1'b1);
      rd(`MIS_ADDR);
      chk_word(got, 32'h1);
      // the clear goes out first, before anything else is serviced
      wr(`RIS_ADDR, 32'h1);
      repeat (2) @(posedge clock);
      chk_pin(irq, 1'b0);
      rd(`RIS_ADDR);
      chk_word(got & 32'hd, 32'hc);
      complete_run();
   end
endmodule : quadrature_position_decoder_test
`default_nettype wire
